// ==== hw/gpcfg_top.sv ====
// Configuration, decode and wake logic of general-purpose pins six to thirteen.
`timescale 1ns/100ps
`default_nettype none
`include "gpcfg_params.svh"
module gpcfg_top #(
  parameter logic [15:0] DB_CYCLES = `GPCFG_DB_CYCLES
) (
  // Clock, reset and clock enable
  input  wire logic        I_CLOCK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_CLK_EN,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [3:0]  I_PSTRB,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Pins six to thirteen, bit 0 is pin six
  input  wire logic [7:0]  I_PIN_IN,
  output logic      [7:0]  O_PIN_OUT,
  output logic      [7:0]  O_PIN_OE,
  output logic      [7:0]  O_PIN_RAIL_SEL,
  // On-chip sources for the alternate and special output functions
  input  wire logic [7:0]  I_SEQ_CTRL,
  input  wire logic        I_WAKE_READY_FEEDBACK,
  input  wire logic        I_SUPPLY_FAULT,
  input  wire logic        I_VSYS_MONITOR,
  input  wire logic        I_BLINK,
  // Requests, sense and interrupt
  output logic             O_POWER_REQUEST,
  output logic             O_SECOND_POWER_REQUEST,
  output logic             O_SYSTEM_REQUEST,
  output logic             O_PERIPHERAL_SWITCH_SENSE,
  output logic             O_IRQ
);

  localparam gpcfg_pkg::gpcfg_state_t ST_RST = '{
    cfg:       {4{`GPCFG_CFG_RST}},
    mode:      `GPCFG_MODE_RST,
    wake_mask: `GPCFG_MASK_RST,
    prev_act:  `GPCFG_PREV_ACT_RST,
    default:   '0
  };

  gpcfg_pkg::gpcfg_state_t   st_reg;
  gpcfg_pkg::gpcfg_state_t   st_next;
  gpcfg_pkg::gpcfg_apb_req_t req;
  logic [7:0]      pin_sync;
  logic [7:0]      pin_filt;
  logic [7:0]      db_en;
  logic [7:0]      act_v;
  logic [7:0]      in_v;
  logic [7:0]      wen_v;
  logic [7:0]      typ_v;
  logic [7:0]      mode_v;
  logic [7:0][1:0] func_v;
  logic [7:0]      wake_set;
  logic [7:0]      wake_clr;
  logic [7:0]      rd_byte;
  logic [5:0]      idx;
  logic            hit;
  logic            setup;
  logic            wr_acc;

  assign req    = {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA, I_PSTRB};
  assign idx    = req.addr[7:2];
  assign mode_v = st_reg.mode;

  // --------------------------------------------------------------------------
  // Pin input path
  // --------------------------------------------------------------------------
  gpcfg_sync #(
    .W (8)
  ) u_sync (
    .i_clk    (I_CLOCK),
    .i_rst_n  (I_RESET_N),
    .i_clk_en (I_CLK_EN),
    .i_async  (I_PIN_IN),
    .o_sync   (pin_sync)
  );

  for (genvar p = 0; p < 8; p++) begin : g_pin
    assign func_v[p] = st_reg.cfg[p/2][(p%2)*`GPCFG_NIBBLE_W + `GPCFG_FUNC_POS +: 2];
    assign typ_v[p]  = st_reg.cfg[p/2][(p%2)*`GPCFG_NIBBLE_W + `GPCFG_TYPE_POS];
    assign wen_v[p]  = st_reg.cfg[p/2][(p%2)*`GPCFG_NIBBLE_W + `GPCFG_WEN_POS];
    // Polarity after the debounce filter, so every later stage sees an active-high request.
    assign act_v[p]  = typ_v[p] ? pin_filt[p] : ~pin_filt[p];

    gpcfg_debounce #(
      .CNT_W     (16),
      .DB_CYCLES (DB_CYCLES)
    ) u_db (
      .i_clk    (I_CLOCK),
      .i_rst_n  (I_RESET_N),
      .i_clk_en (I_CLK_EN),
      .i_en     (db_en[p]),
      .i_level  (pin_sync[p]),
      .o_level  (pin_filt[p])
    );
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic lvl;
    logic drive;
    logic od;
    lvl      = 1'b0;
    drive    = 1'b0;
    od       = 1'b0;
    st_next  = st_reg;
    in_v     = '0;
    db_en    = '0;
    wake_set = '0;
    wake_clr = '0;
    rd_byte  = '0;
    hit      = (req.addr[1:0] == 2'h0);

    case (idx)
      `GPCFG_IDX_CFG_6_7:   rd_byte = st_reg.cfg[0];
      `GPCFG_IDX_CFG_8_9:   rd_byte = st_reg.cfg[1];
      `GPCFG_IDX_CFG_10_11: rd_byte = st_reg.cfg[2];
      `GPCFG_IDX_CFG_12_13: rd_byte = st_reg.cfg[3];
      `GPCFG_IDX_MODE_0_7:  rd_byte = {st_reg.mode[1:0], 6'h00};
      `GPCFG_IDX_MODE_8_15: rd_byte = {2'h0, st_reg.mode[7:2]};
      `GPCFG_IDX_WAKE_STAT: rd_byte = st_reg.wake_stat;
      `GPCFG_IDX_WAKE_MASK: rd_byte = st_reg.wake_mask;
      `GPCFG_IDX_PIN_STATE: rd_byte = act_v;
      default:              hit = 1'b0;
    endcase

    // Zero-wait slave: the answer is prepared in setup and shown in access.
    setup          = req.sel & ~req.enable;
    wr_acc         = req.sel & req.enable & st_reg.pready & req.write & hit;
    st_next.pready = setup;
    st_next.prdata = (setup && !req.write && hit) ? {24'h000000, rd_byte} : 32'h00000000;
    st_next.pslverr = setup & ~hit;

    if (wr_acc && req.strb[0]) begin
      case (idx)
        `GPCFG_IDX_CFG_6_7:   st_next.cfg[0] = req.wdata[7:0];
        `GPCFG_IDX_CFG_8_9:   st_next.cfg[1] = req.wdata[7:0];
        `GPCFG_IDX_CFG_10_11: st_next.cfg[2] = req.wdata[7:0];
        `GPCFG_IDX_CFG_12_13: st_next.cfg[3] = req.wdata[7:0];
        `GPCFG_IDX_MODE_0_7:  st_next.mode[1:0] = req.wdata[`GPCFG_MODE_LO_POS +: 2];
        `GPCFG_IDX_MODE_8_15: st_next.mode[7:2] = req.wdata[`GPCFG_MODE_HI_POS +: 6];
        `GPCFG_IDX_WAKE_STAT: wake_clr = req.wdata[7:0];
        `GPCFG_IDX_WAKE_MASK: st_next.wake_mask = req.wdata[7:0];
        default:              wake_clr = '0;
      endcase
    end

    for (int p = 0; p < 8; p++) begin
      lvl   = 1'b0;
      drive = 1'b0;
      od    = 1'b0;
      case (gpcfg_pkg::gpcfg_func_t'(func_v[p]))
        gpcfg_pkg::FUNC_MODE_PP: begin
          drive = 1'b1;
          lvl   = mode_v[p];
        end
        gpcfg_pkg::FUNC_INPUT: begin
          in_v[p] = 1'b1;
        end
        gpcfg_pkg::FUNC_ALT_OUT: begin
          case (p)
            0, 4: begin
              od  = 1'b1;
              lvl = mode_v[p];
            end
            6: begin
              drive = 1'b1;
              lvl   = mode_v[p] ~^ I_VSYS_MONITOR;
            end
            7: begin
              od  = 1'b1;
              lvl = mode_v[p] ~^ I_WAKE_READY_FEEDBACK;
            end
            default: begin
              drive = 1'b1;
              lvl   = mode_v[p] ~^ I_SEQ_CTRL[p];
            end
          endcase
        end
        default: begin
          case (p)
            0, 2, 3, 4: in_v[p] = 1'b1;
            5: begin
              od  = 1'b1;
              lvl = mode_v[p] ^ I_BLINK;
            end
            6: begin
              drive = 1'b1;
              lvl   = mode_v[p] ~^ I_SUPPLY_FAULT;
            end
            7: begin
              drive = 1'b1;
              lvl   = mode_v[p] ~^ I_WAKE_READY_FEEDBACK;
            end
            default: in_v[p] = 1'b0;
          endcase
        end
      endcase
      // An open-drain pin only ever pulls low; a high level releases it.
      st_next.pin_out[p] = od ? 1'b0 : lvl;
      st_next.pin_oe[p]  = od ? ~lvl : drive;
      db_en[p]           = in_v[p] & mode_v[p];
      wake_set[p] = in_v[p] & act_v[p] & ~st_reg.prev_act[p] & ~wen_v[p];
    end

    st_next.prev_act   = act_v;
    st_next.rail_sel   = typ_v;
    st_next.peri_sense = (func_v[0] == gpcfg_pkg::FUNC_SPECIAL) & act_v[0];
    st_next.sys_req    = (func_v[2] == gpcfg_pkg::FUNC_SPECIAL) & act_v[2];
    st_next.pwr_req    = (func_v[3] == gpcfg_pkg::FUNC_SPECIAL) & act_v[3];
    st_next.pwr2_req   = (func_v[4] == gpcfg_pkg::FUNC_SPECIAL) & act_v[4];
    // A wake edge in the cycle of its clear keeps the bit set.
    st_next.wake_stat  = (st_reg.wake_stat & ~wake_clr) | wake_set;
    st_next.irq        = |(st_next.wake_stat & st_next.wake_mask);

    if (!I_CLK_EN) begin
      st_next = st_reg;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign O_PRDATA                  = st_reg.prdata;
  assign O_PREADY                  = st_reg.pready;
  assign O_PSLVERR                 = st_reg.pslverr;
  assign O_PIN_OUT                 = st_reg.pin_out;
  assign O_PIN_OE                  = st_reg.pin_oe;
  assign O_PIN_RAIL_SEL            = st_reg.rail_sel;
  assign O_POWER_REQUEST           = st_reg.pwr_req;
  assign O_SECOND_POWER_REQUEST    = st_reg.pwr2_req;
  assign O_SYSTEM_REQUEST          = st_reg.sys_req;
  assign O_PERIPHERAL_SWITCH_SENSE = st_reg.peri_sense;
  assign O_IRQ                     = st_reg.irq;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);

  a_wake_mask_gate:
    assert property ((st_reg.wake_stat & ~$past(st_reg.wake_stat) & $past(wen_v)) == 8'h00)
    else $error("wake bit set on a masked pin");
  a_rail_follows_type:
    assert property ($past(I_CLK_EN) |-> O_PIN_RAIL_SEL == $past(typ_v))
    else $error("rail select does not follow type bits");
  a_reserved_pin_idle:
    assert property ($past(I_CLK_EN) && $past(func_v[1]) == 2'h0 |-> !O_PIN_OE[1])
    else $error("reserved pin seven is driven");
  a_pin6_open_drain:
    assert property ($past(I_CLK_EN) && $past(func_v[0]) == 2'h2
                     |-> !O_PIN_OUT[0] && (O_PIN_OE[0] == !$past(mode_v[0])))
    else $error("pin six open-drain drive wrong");
  a_power_request:
    assert property ($past(I_CLK_EN) |-> O_POWER_REQUEST ==
                     ($past(func_v[3]) == 2'h0 && $past(typ_v[3]) == $past(pin_filt[3])))
    else $error("power request mismatch");
  a_system_request:
    assert property ($past(I_CLK_EN) |-> O_SYSTEM_REQUEST ==
                     ($past(func_v[2]) == 2'h0 && $past(act_v[2])))
    else $error("system request mismatch");
  a_blink_open_drain:
    assert property ($past(I_CLK_EN) && $past(func_v[5]) == 2'h0
                     |-> !O_PIN_OUT[5] && O_PIN_OE[5] == ($past(mode_v[5]) == $past(I_BLINK)))
    else $error("pin eleven blink drive wrong");
  a_second_power:
    assert property ($past(I_CLK_EN) |-> O_SECOND_POWER_REQUEST ==
                     ($past(func_v[4]) == 2'h0 && $past(act_v[4])))
    else $error("second power request mismatch");
  a_feedback_drive:
    assert property ($past(I_CLK_EN) && $past(func_v[7]) == 2'h0 |-> O_PIN_OE[7] &&
                     O_PIN_OUT[7] == ($past(mode_v[7]) == $past(I_WAKE_READY_FEEDBACK)))
    else $error("pin thirteen feedback drive wrong");
  a_fault_drive:
    assert property ($past(I_CLK_EN) && $past(func_v[6]) == 2'h0 |-> O_PIN_OE[6] &&
                     O_PIN_OUT[6] == ($past(mode_v[6]) == $past(I_SUPPLY_FAULT)))
    else $error("pin twelve fault drive wrong");
  a_mode_level:
    assert property ($past(I_CLK_EN) && $past(func_v[3]) == 2'h3
                     |-> O_PIN_OE[3] && O_PIN_OUT[3] == $past(mode_v[3]))
    else $error("mode-driven level wrong");
  a_seq_polarity:
    assert property ($past(I_CLK_EN) && $past(func_v[2]) == 2'h2
                     |-> O_PIN_OUT[2] == ($past(mode_v[2]) == $past(I_SEQ_CTRL[2])))
    else $error("sequencer polarity wrong");
  a_wake_on_edge:
    assert property (I_CLK_EN && in_v[2] && !wen_v[2] && act_v[2] && !st_reg.prev_act[2]
                     |=> st_reg.wake_stat[2])
    else $error("wake edge lost");
  a_input_not_driven:
    assert property ($past(I_CLK_EN) && $past(func_v[1]) == 2'h1 |-> !O_PIN_OE[1])
    else $error("input pin seven is driven");
  a_pin10_open_drain:
    assert property ($past(I_CLK_EN) && $past(func_v[4]) == 2'h2
                     |-> !O_PIN_OUT[4] && (O_PIN_OE[4] == !$past(mode_v[4])))
    else $error("pin ten open-drain drive wrong");
  a_refused_read_zero:
    assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h00000000)
    else $error("refused access returned data");
  a_apb_zero_wait:
    assert property (I_CLK_EN && I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("slave did not answer in access phase");

  c_wake_event:   cover property (wake_set != 8'h00 ##1 O_IRQ);
  c_power_req:    cover property ($rose(O_POWER_REQUEST));
  c_apb_write:    cover property (wr_acc);
  c_irq_cleared:  cover property (O_IRQ ##[1:20] !O_IRQ);

endmodule // gpcfg_top
`default_nettype wire

// ==== hw/gpcfg_params.svh ====
// Offsets, field positions, reset values and counts of the pin six to thirteen configuration.
`ifndef GPCFG_PARAMS_SVH
`define GPCFG_PARAMS_SVH

// Register indices; the APB byte address is four times the index.
`define GPCFG_IDX_CFG_6_7    6'h18
`define GPCFG_IDX_CFG_8_9    6'h19
`define GPCFG_IDX_CFG_10_11  6'h1a
`define GPCFG_IDX_CFG_12_13  6'h1b
`define GPCFG_IDX_MODE_0_7   6'h1d
`define GPCFG_IDX_MODE_8_15  6'h1e
`define GPCFG_IDX_WAKE_STAT  6'h20
`define GPCFG_IDX_WAKE_MASK  6'h21
`define GPCFG_IDX_PIN_STATE  6'h22

// Field positions inside one pin nibble, and nibble width.
`define GPCFG_FUNC_POS       3'h0
`define GPCFG_TYPE_POS       3'h2
`define GPCFG_WEN_POS        3'h3
`define GPCFG_NIBBLE_W       3'h4

// Mode bit positions: pins six and seven, and pins eight to thirteen.
`define GPCFG_MODE_LO_POS    3'h6
`define GPCFG_MODE_HI_POS    3'h0

// Reset values.
`define GPCFG_CFG_RST        8'h99
`define GPCFG_MODE_RST       8'h00
`define GPCFG_MASK_RST       8'h00
// Edge history starts at the active levels that reset presents, so no false wake edge follows.
`define GPCFG_PREV_ACT_RST   8'hff

// Debounce settling time in clock cycles.
`define GPCFG_DB_CYCLES      16'h00c8

`endif

// ==== hw/gpcfg_pkg.sv ====
// Types shared by the pin configuration block.
`default_nettype none
package gpcfg_pkg;

  // Two-bit pin function field.
  typedef enum logic [1:0] {
    FUNC_SPECIAL = 2'h0,
    FUNC_INPUT   = 2'h1,
    FUNC_ALT_OUT = 2'h2,
    FUNC_MODE_PP = 2'h3
  } gpcfg_func_t;

  // APB request as seen by the slave.
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } gpcfg_apb_req_t;

  // Whole state of the top module.
  typedef struct packed {
    logic [3:0][7:0] cfg;
    logic [7:0]      mode;
    logic [7:0]      wake_stat;
    logic [7:0]      wake_mask;
    logic [7:0]      prev_act;
    logic [7:0]      pin_out;
    logic [7:0]      pin_oe;
    logic [7:0]      rail_sel;
    logic            pwr_req;
    logic            pwr2_req;
    logic            sys_req;
    logic            peri_sense;
    logic            irq;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } gpcfg_state_t;

endpackage
`default_nettype wire

// ==== hw/gpcfg_sync.sv ====
// Two-flop synchroniser for pin levels.
`timescale 1ns/100ps
`default_nettype none
module gpcfg_sync #(
  parameter int W = 8
) (
  // Clock, reset and enable
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clk_en,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gpcfg_sync_state_t;

  gpcfg_sync_state_t st_reg;
  gpcfg_sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (i_clk_en) begin
      st_next.stage1 = i_async;
      st_next.stage2 = st_reg.stage1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.stage2;

endmodule // gpcfg_sync
`default_nettype wire

// ==== hw/gpcfg_debounce.sv ====
// Optional debounce filter for one synchronised pin level.
`timescale 1ns/100ps
`default_nettype none
`include "gpcfg_params.svh"
module gpcfg_debounce #(
  parameter int              CNT_W     = 16,
  parameter logic [CNT_W-1:0] DB_CYCLES = `GPCFG_DB_CYCLES
) (
  // Clock, reset and enable
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  // Filter
  input  wire logic i_en,
  input  wire logic i_level,
  output logic      o_level
);

  typedef struct packed {
    logic             level;
    logic [CNT_W-1:0] cnt;
  } gpcfg_db_state_t;

  gpcfg_db_state_t st_reg;
  gpcfg_db_state_t st_next;

  // With filtering off the level passes with one cycle of latency.
  always_comb begin
    st_next = st_reg;
    if (!i_en || (i_level == st_reg.level)) begin
      st_next.level = i_level;
      st_next.cnt   = '0;
    end else if (st_reg.cnt >= DB_CYCLES - 1'b1) begin
      st_next.level = i_level;
      st_next.cnt   = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    if (!i_clk_en) begin
      st_next = st_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.level;

endmodule // gpcfg_debounce
`default_nettype wire

// ==== bench/gpcfg_board.sv ====
// Board and sequencer model facing pins six to thirteen.
`timescale 1ns/100ps
`default_nettype none
module gpcfg_board (
  // Clock
  input  wire logic        i_clk,
  // Device pin drivers
  input  wire logic [7:0]  i_pin_out,
  input  wire logic [7:0]  i_pin_oe,
  // Bench commands
  input  wire logic [7:0]  i_ext_level,
  input  wire logic [11:0] i_src,
  // Toward the device
  output logic      [7:0]  o_pin_level,
  output logic      [7:0]  o_seq_ctrl,
  output logic             o_feedback,
  output logic             o_fault,
  output logic             o_vsys,
  output logic             o_blink
);
  // ---------------------------------------------------------------
  // Pin wires and on-chip sources
  // ---------------------------------------------------------------
  // A released pin shows the board level, which stands in for the pull-up or the far driver.
  assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);

  // Sources share the device clock, so they change only just after an edge.
  always_ff @(posedge i_clk) begin
    o_seq_ctrl <= i_src[7:0];
    {o_feedback, o_fault, o_vsys, o_blink} <= i_src[11:8];
  end
endmodule // gpcfg_board
`default_nettype wire

// ==== bench/test_gpcfg_top.sv ====
// Self-checking bench for the pin six to thirteen configuration block.
`timescale 1ns/100ps
`default_nettype none
module test_gpcfg_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic [31:0] d;
    logic        err;
  } gpcfg_exp_t;
  localparam logic [7:0] ADDR [6] = '{8'h60, 8'h64, 8'h68, 8'h6c, 8'h74, 8'h78};
  localparam logic [7:0] KEEP [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hc0, 8'h3f};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  ext_level = 8'hff;
  logic [11:0] src = 12'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, pwr, pwr2, sys, peri, irq, fb, fault, vsys, blink;
  logic [7:0]  pin_out, pin_oe, rail, pin_level, seq;
  gpcfg_exp_t  exp_q[$];
  gpcfg_exp_t  e;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  gpcfg_top #(.DB_CYCLES(16'h0004)) u_gpcfg_top (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_CLK_EN(1'b1),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(4'hf), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PIN_IN(pin_level), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe),
    .O_PIN_RAIL_SEL(rail), .I_SEQ_CTRL(seq), .I_WAKE_READY_FEEDBACK(fb),
    .I_SUPPLY_FAULT(fault), .I_VSYS_MONITOR(vsys), .I_BLINK(blink),
    .O_POWER_REQUEST(pwr), .O_SECOND_POWER_REQUEST(pwr2), .O_SYSTEM_REQUEST(sys),
    .O_PERIPHERAL_SWITCH_SENSE(peri), .O_IRQ(irq));

  gpcfg_board u_gpcfg_board (
    .i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_level(ext_level),
    .i_src(src), .o_pin_level(pin_level), .o_seq_ctrl(seq), .o_feedback(fb),
    .o_fault(fault), .o_vsys(vsys), .o_blink(blink));

  initial forever #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic fail(input string msg);
    err_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("bus got %h expected %h", got, exp));
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("pin out/oe got %b expected %b", got, exp));
  endtask

  task automatic chk_lvl(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("level got %b expected %b", got, exp));
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // An idle cycle opens every transfer, so the strobes never change twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic err);
    int n;
    exp_q.push_back('{rd: ~w, d: d, err: err});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail("no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle;
    repeat (16) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected answer");
      else begin
        e = exp_q.pop_front();
        if (e.rd) chk_bus(prdata, e.d);
        chk_bus({31'h0, pslverr}, {31'h0, e.err});
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail("timeout");
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    int t, m, c;
    logic [31:0] r;
    r = $urandom(60447);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (c = 0; c < 4; c++) apb(1'b0, ADDR[c], 32'h99, 1'b0);
    apb(1'b0, 8'h74, 32'h0, 1'b0);
    apb(1'b0, 8'h84, 32'h0, 1'b0);
    for (c = 0; c < 6; c++) begin
      r = $urandom;
      apb(1'b1, ADDR[c], {24'h0, r[7:0]}, 1'b0);
      apb(1'b0, ADDR[c], {24'h0, r[7:0] & KEEP[c]}, 1'b0);
    end
    apb(1'b1, 8'h70, 32'h5a, 1'b1);
    apb(1'b0, 8'h70, 32'h0, 1'b1);
    apb(1'b0, 8'h61, 32'h0, 1'b1);
    for (m = 0; m < 2; m++) for (t = 0; t < 2; t++) for (c = 2; c < 4; c++) begin
      r = $urandom;
      src <= {r[11:9], 1'b0, r[7:0]};
      apb(1'b1, 8'h74, {24'h0, m[0], m[0], 6'h0}, 1'b0);
      apb(1'b1, 8'h60, {24'h0, 1'b1, t[0], c[1:0], 1'b1, t[0], c[1:0]}, 1'b0);
      settle();
      chk_pin({pin_out[0], pin_oe[0]}, c == 3 ? {m[0], 1'b1} : {1'b0, ~m[0]});
      chk_pin({pin_out[1], pin_oe[1]}, {c == 3 ? m[0] : ~(m[0] ^ src[1]), 1'b1});
      chk_lvl({6'h0, rail[1:0]}, {6'h0, t[0], t[0]});
    end
    apb(1'b1, 8'h78, 32'h7, 1'b0);
    for (t = 0; t < 2; t++) begin
      apb(1'b1, 8'h64, {24'h0, 1'b1, t[0], 2'b00, 1'b1, t[0], 2'b00}, 1'b0);
      apb(1'b1, 8'h68, {24'h0, 4'hb, 1'b1, t[0], 2'b00}, 1'b0);
      apb(1'b1, 8'h60, {24'h0, 4'h9, 1'b1, t[0], 2'b00}, 1'b0);
      for (m = 0; m < 2; m++) begin
        ext_level <= {8{m[0]}};
        settle();
        chk_lvl({4'h0, pwr, pwr2, sys, peri}, {4'h0, {4{m[0] == t[0]}}});
      end
    end
    for (m = 0; m < 2; m++) for (c = 0; c < 2; c++) begin
      r = $urandom;
      src <= r[11:0];
      apb(1'b1, 8'h78, {24'h0, 2'b00, m[0], m[0], 1'b0, m[0], 2'b00}, 1'b0);
      apb(1'b1, 8'h6c, {24'h0, 4'h8, c ? 4'ha : 4'h8}, 1'b0);
      apb(1'b1, 8'h68, {24'h0, 4'h8, c ? 4'hb : 4'ha}, 1'b0);
      settle();
      chk_pin({pin_out[6], pin_oe[6]}, {~(m[0] ^ (c ? src[9] : src[10])), 1'b1});
      chk_pin({pin_out[7], pin_oe[7]}, {~(m[0] ^ src[11]), 1'b1});
      chk_pin({pin_out[4], pin_oe[4]}, c ? {m[0], 1'b1} : {1'b0, ~m[0]});
      chk_pin({pin_out[5], pin_oe[5]}, {1'b0, ~src[8]});
    end
    apb(1'b1, 8'h78, 32'h0, 1'b0);
    apb(1'b1, 8'h84, 32'h4, 1'b0);
    for (t = 0; t < 2; t++) begin
      ext_level <= {8{~t[0]}};
      apb(1'b1, 8'h64, {24'h0, 4'h9, 1'b0, t[0], 2'b01}, 1'b0);
      settle();
      apb(1'b1, 8'h80, 32'hff, 1'b0);
      settle();
      chk_lvl({7'h0, irq}, 8'h0);
      ext_level <= {8{t[0]}};
      settle();
      chk_lvl({7'h0, irq}, 8'h1);
      apb(1'b0, 8'h80, 32'h4, 1'b0);
      apb(1'b1, 8'h84, 32'h0, 1'b0);
      settle();
      chk_lvl({7'h0, irq}, 8'h0);
      apb(1'b1, 8'h84, 32'h4, 1'b0);
      apb(1'b1, 8'h80, 32'h4, 1'b0);
      settle();
      chk_lvl({7'h0, irq}, 8'h0);
      apb(1'b0, 8'h80, 32'h0, 1'b0);
    end
    ext_level <= 8'h00;
    apb(1'b1, 8'h64, {24'h0, 4'h9, 4'hd}, 1'b0);
    settle();
    apb(1'b1, 8'h80, 32'hff, 1'b0);
    ext_level <= 8'hff;
    settle();
    apb(1'b0, 8'h80, 32'h0, 1'b0);
    test_done();
  end
endmodule // test_gpcfg_top
`default_nettype wire
